/* File: verif/rnp_board.sv */
`timescale 1ns/1ps
`default_nettype none
// Board side: reset switch with pull-up, and the NMI source
module rnp_board
(
  // Controls from the bench
  input  wire logic  press,
  input  wire logic  nmi_lvl,
  // Device pull on the reset line
  input  wire logic  dev_oe,
  // Lines to the device
  output logic       rst_line,
  output logic       nmi_line,
  // Software setting kept by the board's firmware stand-in
  output logic       low_freq_osc_off
);
  // The slow oscillator is unused here, so software keeps it off
  assign low_freq_osc_off = 1'b1;
  // Pull-up wins unless the switch or the device pulls low
  assign rst_line = !(press || dev_oe);
  // NMI sits high unless the source pulls it low
  assign nmi_line = nmi_lvl;
endmodule
`default_nettype wire

/* File: verif/tb_rnp_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_rnp_top;
  logic mclk, rst_b, press, nmi_lvl, bidir, wake, sw, wdt, eoi, pd;
  wire  rpin, nmi, pout, oe, ind, crst, trap, pde, osc_off;
  int   error_cnt = 0;
  int   n_compared = 0;
  // Short counts keep the run brief
  localparam int RST_MIN = 4;
  rnp_board rnp_board_i (.press(press), .nmi_lvl(nmi_lvl), .dev_oe(oe),
    .rst_line(rpin), .nmi_line(nmi), .low_freq_osc_off(osc_off));
  rnp_top #(.RESET_MIN(RST_MIN), .SEQ_LEN(8)) rnp_top_i (.mclk(mclk),
    .rst_b(rst_b), .reset_input_pin(rpin), .reset_pin_out(pout),
    .reset_pin_oe(oe), .reset_indication_output(ind),
    .bidir_reset_enable(bidir), .powerdown_wake_config(wake),
    .sw_reset_req(sw), .wdt_reset_req(wdt),
    .end_of_init_instruction(eoi), .powerdown_instruction(pd),
    .nmi_pin(nmi), .core_reset(crst), .nmi_trap_req(trap),
    .powerdown_enter(pde));
  // Clock, 10 ns period
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_n(input int got, input int exp);
    n_compared++;
    if (got != exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask
  // Let edges pass, then sample settled outputs
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic finish_init();
    for (int i = 0; i < 40 && crst !== 1'b0; i++) tick(1);
    chk(crst, 1'b0);
    chk(ind, 1'b0);
    @(posedge mclk) eoi <= 1'b1;
    @(posedge mclk) eoi <= 1'b0;
    tick(2);
    chk(ind, 1'b1);
  endtask
  // One trap pulse for a fall, none for the rise
  task automatic t_nmi();
    int hits = 0;
    @(posedge mclk) nmi_lvl <= 1'b0;
    repeat (8)
    begin
      tick(1);
      if (trap === 1'b1)
        hits++;
    end
    @(posedge mclk) nmi_lvl <= 1'b1;
    repeat (8)
    begin
      tick(1);
      if (trap === 1'b1)
        hits++;
    end
    chk_n(hits, 1);
  endtask
  task automatic t_pd();
    @(posedge mclk) pd <= 1'b1;
    @(posedge mclk) pd <= 1'b0;
    #1 chk(pde, 1'b0);
    @(posedge mclk) nmi_lvl <= 1'b0;
    tick(5);
    @(posedge mclk) pd <= 1'b1;
    @(posedge mclk) pd <= 1'b0;
    #1 chk(pde, 1'b1);
    @(posedge mclk) nmi_lvl <= 1'b1;
    tick(6);
    // Wake config 1: power-down no longer waits for a low NMI
    @(posedge mclk) wake <= 1'b1;
    pd <= 1'b1;
    @(posedge mclk) pd <= 1'b0;
    wake <= 1'b0;
    #1 chk(pde, 1'b1);
    tick(1);
    chk(pde, 1'b0);
  endtask
  // Reset pin low for n edges; only the full minimum resets
  task automatic t_press(input int n);
    @(posedge mclk) press <= 1'b1;
    repeat (n) @(posedge mclk);
    press <= 1'b0;
    tick(3);
    chk(crst, n >= RST_MIN);
    chk(ind, n < RST_MIN);
    if (n >= RST_MIN)
      finish_init();
  endtask
  // Mid-run reset: outputs at reset values, then a clean restart
  task automatic t_por();
    @(posedge mclk) rst_b <= 1'b0;
    tick(2);
    chk(crst, 1'b1);
    chk(ind, 1'b0);
    chk(oe, 1'b0);
    chk(trap, 1'b0);
    chk(pde, 1'b0);
    @(posedge mclk) rst_b <= 1'b1;
    tick(2);
    chk(oe, bidir);
    finish_init();
  endtask
  // Kind 0 software, 1 watchdog, 2 reset pin held low
  task automatic t_rst(input int kind);
    @(posedge mclk);
    sw <= (kind == 0);
    wdt <= (kind == 1);
    press <= (kind == 2);
    bidir <= (kind != 0);
    repeat (kind == 2 ? 8 : 1) @(posedge mclk);
    sw <= 1'b0;
    wdt <= 1'b0;
    press <= 1'b0;
    tick(2);
    chk(crst, 1'b1);
    chk(ind, 1'b0);
    chk(oe, kind != 0);
    chk(rpin, kind == 0);
    chk(pout, 1'b0);
    finish_init();
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Watchdog against a hang
  initial
  begin
    #50us;
    error_cnt++;
    conclude();
  end
  // Main sequence
  initial
  begin
    rst_b = 1'b0; press = 1'b0; nmi_lvl = 1'b1; bidir = 1'b0;
    wake = 1'b0; sw = 1'b0; wdt = 1'b0; eoi = 1'b0; pd = 1'b0;
    tick(5);
    chk(osc_off, 1'b1);
    chk(crst, 1'b1);
    chk(ind, 1'b0);
    @(posedge mclk) rst_b <= 1'b1;
    @(posedge mclk) eoi <= 1'b1;
    @(posedge mclk) eoi <= 1'b0;
    tick(2);
    chk(ind, 1'b0);
    finish_init();
    t_nmi();
    t_pd();
    t_press(RST_MIN - 1);
    t_press(RST_MIN);
    for (int k = 0; k < 3; k++) t_rst(k);
    t_por();
    conclude();
  end
endmodule
`default_nettype wire

/* File: verilog/rnp_nmi_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Carries the synchronised NMI level and edge between modules
interface rnp_nmi_if;
  logic level;
  logic fall;
  modport src (output level, output fall);
  modport dst (input level, input fall);
endinterface
`default_nettype wire

/* File: verilog/rnp_nmi_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module rnp_nmi_sync
(
  // Clock and reset
  input  wire logic  mclk,
  input  wire logic  rst_b,
  // Pin
  input  wire logic  nmi_pin,
  // Result
  rnp_nmi_if.src     nmi
);
  logic [1:0] sync;
  logic       prev;

  // Two-flop synchroniser, idle high
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
      sync <= rnp_pkg::SYNC_IDLE;
    else
      sync <= {sync[0], nmi_pin};

  // Previous synchronised sample
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
      prev <= 1'h1;
    else
      prev <= sync[1];

  // Falling edge from two synchronised samples
  assign nmi.level = sync[1];
  assign nmi.fall  = prev & ~sync[1];

  nmi_edge_a: assert property (@(posedge mclk) disable iff (!rst_b)
    nmi.fall |-> $past(sync[1]) && !sync[1])
    else $error("nmi edge not from two synced samples");
endmodule
`default_nettype wire

/* File: verilog/rnp_pkg.sv */
package rnp_pkg;
  // Reset input must stay low this long before it is believed (ns)
  localparam int RESET_MIN_NS = 1000;
  localparam int CLK_PERIOD_NS = 10;
  // Least time rounds up to whole cycles
  localparam int RESET_MIN_CYC =
    (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Length of the internal reset sequence (ns)
  localparam int SEQ_NS = 2000;
  localparam int SEQ_CYC = (SEQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [1:0] SYNC_IDLE = 2'h3;
  localparam logic       PWD_NMI_GATED = 1'h0;

  // Sequencer states
  typedef enum logic [2:0] {
    RNP_RUN   = 3'h1,
    RNP_SEQ   = 3'h2,
    RNP_INIT  = 3'h4
  } rnp_state_type;
endpackage

/* File: verilog/rnp_top.sv */
// How it works
// - Reset pin held low the minimum time while clocked resets device.
// - Bidirectional mode: device pulls reset line low during sequence.
// - Indication low during hardware, software or watchdog reset.
// - Reset indication stays low until end-of-init instruction executes.
// - NMI falling edge while running, after end of init, raises the NMI trap request to the CPU.
// - With wake config 0, power-down enters only when NMI is low.
// - Wake config 0 and NMI high: power-down instruction is ignored.
`timescale 1ns/1ps
`default_nettype none
module rnp_top
#(
  parameter int RESET_MIN = rnp_pkg::RESET_MIN_CYC,
  parameter int SEQ_LEN   = rnp_pkg::SEQ_CYC
)
(
  // Clock and reset
  input  wire logic  mclk,
  input  wire logic  rst_b,
  // Reset pin, open drain
  input  wire logic  reset_input_pin,
  output logic       reset_pin_out,
  output logic       reset_pin_oe,
  // Reset indication
  output logic       reset_indication_output,
  // Configuration
  input  wire logic  bidir_reset_enable,
  input  wire logic  powerdown_wake_config,
  // CPU side events, and the NMI pin
  input  wire logic  sw_reset_req,
  input  wire logic  wdt_reset_req,
  input  wire logic  end_of_init_instruction,
  input  wire logic  powerdown_instruction,
  input  wire logic  nmi_pin,
  // Results
  output logic       core_reset,
  output logic       nmi_trap_req,
  output logic       powerdown_enter
);
  rnp_nmi_if                 nmi ();
  rnp_pkg::rnp_state_type    state;
  logic [rnp_pkg::CNT_W-1:0] low_cnt;
  logic [rnp_pkg::CNT_W-1:0] seq_cnt;
  logic                      hw_reset;
  logic                      any_reset;
  logic                      pd_allowed;

  // State tests shared by the filter, pin, indication and trap logic
  function automatic logic is_seq(input rnp_pkg::rnp_state_type s);
    return s == rnp_pkg::RNP_SEQ;
  endfunction

  function automatic logic is_run(input rnp_pkg::rnp_state_type s);
    return s == rnp_pkg::RNP_RUN;
  endfunction

  rnp_nmi_sync u_sync
  (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .nmi_pin (nmi_pin),
    .nmi     (nmi)
  );

  // Held-low filter on the reset pin, ignoring our own drive
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
      low_cnt <= rnp_pkg::CNT_ZERO;
    else if (reset_input_pin || is_seq(state))
      low_cnt <= rnp_pkg::CNT_ZERO;
    else if (!hw_reset)
      low_cnt <= low_cnt + rnp_pkg::CNT_ONE;

  assign hw_reset = (low_cnt == rnp_pkg::CNT_W'(RESET_MIN));
  assign any_reset = hw_reset || sw_reset_req || wdt_reset_req;

  // Reset sequencer
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
    begin
      state   <= rnp_pkg::RNP_SEQ;
      seq_cnt <= rnp_pkg::CNT_ZERO;
    end
    else if (any_reset)
    begin
      state   <= rnp_pkg::RNP_SEQ;
      seq_cnt <= rnp_pkg::CNT_ZERO;
    end
    else
    begin
      unique case (state)
        rnp_pkg::RNP_SEQ:
          if (seq_cnt == rnp_pkg::CNT_W'(SEQ_LEN - 1))
            state <= rnp_pkg::RNP_INIT;
          else
            seq_cnt <= seq_cnt + rnp_pkg::CNT_ONE;
        rnp_pkg::RNP_INIT:
          if (end_of_init_instruction)
            state <= rnp_pkg::RNP_RUN;
        rnp_pkg::RNP_RUN:
          state <= rnp_pkg::RNP_RUN;
        default:
          state <= rnp_pkg::RNP_SEQ;
      endcase
    end

  // Pin drive and indication, all registered
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
    begin
      reset_pin_out           <= 1'h0;
      reset_pin_oe            <= 1'h0;
      reset_indication_output <= 1'h0;
      core_reset              <= 1'h1;
    end
    else
    begin
      reset_pin_out <= 1'h0;
      reset_pin_oe  <= bidir_reset_enable &&
                       (any_reset || is_seq(state));
      reset_indication_output <= !any_reset &&
                       is_run(state);
      core_reset <= any_reset || is_seq(state);
    end

  assign pd_allowed = powerdown_wake_config != rnp_pkg::PWD_NMI_GATED ||
                      !nmi.level;

  // NMI trap and power-down gating
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
    begin
      nmi_trap_req    <= 1'h0;
      powerdown_enter <= 1'h0;
    end
    else
    begin
      nmi_trap_req    <= nmi.fall && is_run(state);
      powerdown_enter <= powerdown_instruction && pd_allowed &&
                         is_run(state);
    end

  sequence s_eoi;
    state == rnp_pkg::RNP_INIT && end_of_init_instruction && !any_reset;
  endsequence

  rsto_release_a: assert property (@(posedge mclk) disable iff (!rst_b)
    s_eoi |=> ##1 reset_indication_output)
    else $error("indication not released after end of init");
  rsto_low_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (sw_reset_req || wdt_reset_req) |=>
      !reset_indication_output)
    else $error("indication high during reset");
  pin_pull_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (state == rnp_pkg::RNP_SEQ && bidir_reset_enable) |=>
      reset_pin_oe)
    else $error("reset pin not pulled during sequence");
  hw_reset_a: assert property (@(posedge mclk) disable iff (!rst_b)
    hw_reset |=> state == rnp_pkg::RNP_SEQ)
    else $error("held-low reset ignored");
  nmi_trap_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (nmi.fall && state == rnp_pkg::RNP_RUN) |=> nmi_trap_req)
    else $error("nmi edge lost");
  pd_enter_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (powerdown_instruction && !powerdown_wake_config && !nmi.level &&
     state == rnp_pkg::RNP_RUN) |=> powerdown_enter)
    else $error("power-down not entered with nmi low");
  pd_block_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (!powerdown_wake_config && nmi.level) |=> !powerdown_enter)
    else $error("power-down entered with nmi high");
  pin_quiet_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !bidir_reset_enable |=> !reset_pin_oe)
    else $error("reset pin driven in input mode");

  // Steady running and a released reset pin, used as antecedents
  sequence s_run_calm;
    state == rnp_pkg::RNP_RUN && !any_reset;
  endsequence

  sequence s_pin_released;
    reset_input_pin;
  endsequence

  // A released pin clears the filter before it can fire
  pin_filter_a: assert property (@(posedge mclk) disable iff (!rst_b)
    s_pin_released |=> !hw_reset)
    else $error("reset filter fired after pin release");

  // Every reset request enters the sequence and holds the core
  core_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
    any_reset |=> core_reset && state == rnp_pkg::RNP_SEQ)
    else $error("core not held in reset");

  // The sequence, and with it the pin pull, lasts its full length
  seq_stay_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (state == rnp_pkg::RNP_SEQ &&
     seq_cnt != rnp_pkg::CNT_W'(SEQ_LEN - 1)) |=>
      state == rnp_pkg::RNP_SEQ)
    else $error("reset sequence cut short");

  // The sequencer never skips the wait for end of init
  seq_order_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (state == rnp_pkg::RNP_SEQ) |=>
      (state != rnp_pkg::RNP_RUN))
    else $error("sequencer skipped the init wait");

  // Indication stays low whenever the sequencer is not running
  ind_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (state != rnp_pkg::RNP_RUN) |=> !reset_indication_output)
    else $error("indication released before end of init");

  // A running device keeps running until a reset request arrives
  run_stay_a: assert property (@(posedge mclk) disable iff (!rst_b)
    s_run_calm |=> state == rnp_pkg::RNP_RUN)
    else $error("running state left without a reset");

  // Trap requests come only from a synchronised falling edge
  nmi_only_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !nmi.fall |=> !nmi_trap_req)
    else $error("trap raised without an nmi edge");

  // Power-down follows only the instruction, and only while running
  pd_cause_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !(powerdown_instruction && state == rnp_pkg::RNP_RUN) |=>
      !powerdown_enter)
    else $error("power-down entered without the instruction");
endmodule
`default_nettype wire
